// ===== hw/rpt_defines.vh
`ifndef RPT_DEFINES_VH
`define RPT_DEFINES_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RPT_ADDR_CTRL 4'h0
`define RPT_ADDR_PIN 4'h1
`define RPT_ADDR_MODE 4'h2
`define RPT_ADDR_ROUTE 4'h3
`define RPT_ADDR_PRE 4'h4
`define RPT_ADDR_MAIN 4'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RPT_CTRL_START 0
`define RPT_CTRL_STOP 2
`define RPT_PIN_LEVEL 0
`define RPT_PIN_OSTOP 2
`define RPT_PIN_INVEN 3
`define RPT_PIN_PORT1 4
`define RPT_PIN_PORT2 5
`define RPT_MODE_SRC_LSB 4
`define RPT_MODE_SRC_MSB 6

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define RPT_RST_BYTE 8'h00
`define RPT_RST_CNT 8'hff
`define RPT_SRC_DIV1 3'h0
`define RPT_SRC_DIV8 3'h1
`define RPT_SRC_OSC 3'h2
`define RPT_SRC_DIV2 3'h3
`define RPT_SRC_SUB32 3'h4
`define RPT_SRC_SUB 3'h6
`define RPT_ROUTE_A 2'h1
`define RPT_ROUTE_B 2'h2

`endif

// ===== hw/rpt_timer.v
// Function
// - 8-bit main counter behind 8-bit prescaler
// - Each stage reload plus counter, one address
// - Pulse mode toggles primary pin on underflow
// - Decrement, reload on underflow, keep counting
// - Division is (pre+1)(main+1)
// - Six selectable count sources
// - Writing start bit 1 starts counting
// - Start 0 or forced stop 1 halts
// - Interrupt request on main underflow
// - Inverted pin copies complement when enabled
// - Polarity bit sets starting output level
// - Mode register write forces starting level
// - Output stop bit stops primary drive
// - Two-bit field routes primary to pin
// - Stopped write loads reload and counter
// - Running write also loads both
// - Reads return count, not reload
// - Primary pin is pulse or port
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "rpt_defines.vh"

module rpt_timer
#(
    parameter WIDTH = 8
)
(
    input wire mclk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire osc_clk_i,
    input wire sub_clk_i,
    output reg [7:0] rdata_o,
    output reg irq_o,
    output reg pin_a_o,
    output reg pin_a_oe_o,
    output reg pin_b_o,
    output reg pin_b_oe_o,
    output reg inv_pin_o,
    output reg inv_pin_oe_o
);

    // ----------------------------------------
    // Software state
    // ----------------------------------------
    reg count_start_bit;
    reg [7:0] pin_control_reg;
    reg [7:0] timer_mode_reg;
    reg [1:0] pin_route_reg;
    reg [WIDTH-1:0] pre_reload;
    reg [WIDTH-1:0] prescaler_value;
    reg [WIDTH-1:0] main_reload;
    reg [WIDTH-1:0] main_count_value;
    reg pulse_level;
    reg [2:0] div_cnt;
    reg [4:0] sub_div;
    reg [2:0] osc_sync;
    reg [2:0] sub_sync;
    reg osc_level;
    reg sub_level;
    reg osc_prev;
    reg sub_prev;
    reg sub_cnt_prev;
    reg tick;
    reg sub32_pulse;

    wire start_level_select = pin_control_reg[`RPT_PIN_LEVEL];
    wire pulse_output_stop = pin_control_reg[`RPT_PIN_OSTOP];
    wire inverted_output_enable = pin_control_reg[`RPT_PIN_INVEN];
    wire [2:0] src_sel = timer_mode_reg[`RPT_MODE_SRC_MSB:`RPT_MODE_SRC_LSB];
    wire wr_ctrl = wr_i && addr_i == `RPT_ADDR_CTRL;
    wire wr_pre = wr_i && addr_i == `RPT_ADDR_PRE;
    wire wr_main = wr_i && addr_i == `RPT_ADDR_MAIN;
    wire wr_mode = wr_i && addr_i == `RPT_ADDR_MODE;

    // ----------------------------------------
    // Foreign clocks, three-stage sampling
    // ----------------------------------------
    // Oscillator and sub-clock are far slower than mclk, so edge
    // detection on the filtered level is enough to make a tick.
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            osc_sync <= 3'h0;
            sub_sync <= 3'h0;
            osc_level <= 1'b0;
            sub_level <= 1'b0;
            osc_prev <= 1'b0;
            sub_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            osc_sync <= {osc_sync[1:0], osc_clk_i};
            sub_sync <= {sub_sync[1:0], sub_clk_i};
            if (osc_sync[1] == osc_sync[2])
                osc_level <= osc_sync[2];
            if (sub_sync[1] == sub_sync[2])
                sub_level <= sub_sync[2];
            osc_prev <= osc_level;
            sub_prev <= sub_level;
        end
    end

    wire osc_rise = osc_level && !osc_prev;
    wire sub_rise = sub_level && !sub_prev;

    // ----------------------------------------
    // Count source dividers
    // ----------------------------------------
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            div_cnt <= 3'h0;
            sub_div <= 5'h00;
            sub_cnt_prev <= 1'b0;
            sub32_pulse <= 1'b0;
        end
        else if (ce_i)
        begin
            div_cnt <= div_cnt + 3'h1;
            if (sub_rise)
                sub_div <= sub_div + 5'h01;
            sub_cnt_prev <= sub_div[4];
            sub32_pulse <= sub_div[4] && !sub_cnt_prev;
        end
    end

    always @*
    begin
        case (src_sel)
            `RPT_SRC_DIV1: tick = 1'b1;
            `RPT_SRC_DIV2: tick = div_cnt[0];
            `RPT_SRC_DIV8: tick = div_cnt == 3'h7;
            `RPT_SRC_OSC: tick = osc_rise;
            `RPT_SRC_SUB32: tick = sub32_pulse;
            `RPT_SRC_SUB: tick = sub_rise;
            default: tick = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Counting chain
    // ----------------------------------------
    wire pre_zero = prescaler_value == {WIDTH{1'b0}};
    wire main_zero = main_count_value == {WIDTH{1'b0}};
    wire run_tick = count_start_bit && tick;
    wire main_under = run_tick && pre_zero && main_zero;

    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            count_start_bit <= 1'b0;
            pin_control_reg <= `RPT_RST_BYTE;
            timer_mode_reg <= `RPT_RST_BYTE;
            pin_route_reg <= 2'h0;
            pre_reload <= `RPT_RST_CNT;
            prescaler_value <= `RPT_RST_CNT;
            main_reload <= `RPT_RST_CNT;
            main_count_value <= `RPT_RST_CNT;
            pulse_level <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_ctrl)
            begin
                if (wdata_i[`RPT_CTRL_STOP])
                    count_start_bit <= 1'b0;
                else
                    count_start_bit <= wdata_i[`RPT_CTRL_START];
            end
            if (wr_i && addr_i == `RPT_ADDR_PIN)
                pin_control_reg <= wdata_i;
            if (wr_i && addr_i == `RPT_ADDR_ROUTE)
                pin_route_reg <= wdata_i[1:0];
            if (wr_mode)
                timer_mode_reg <= wdata_i;
            // Prescaler stage; a write wins over counting
            if (wr_pre)
            begin
                pre_reload <= wdata_i[WIDTH-1:0];
                prescaler_value <= wdata_i[WIDTH-1:0];
            end
            else if (run_tick)
            begin
                if (pre_zero)
                    prescaler_value <= pre_reload;
                else
                    prescaler_value <= prescaler_value - 1'b1;
            end
            // Main stage steps only on prescaler underflow
            if (wr_main)
            begin
                main_reload <= wdata_i[WIDTH-1:0];
                main_count_value <= wdata_i[WIDTH-1:0];
            end
            else if (run_tick && pre_zero)
            begin
                if (main_zero)
                    main_count_value <= main_reload;
                else
                    main_count_value <= main_count_value - 1'b1;
            end
            if (wr_mode)
                pulse_level <= start_level_select;
            else if (main_under)
                pulse_level <= !pulse_level;
        end
    end

    // ----------------------------------------
    // Register reads and pins
    // ----------------------------------------
    // Pins are registered so every output leaves a flip-flop; costs
    // one cycle of delay relative to the internal level.
    always @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 8'h00;
            irq_o <= 1'b0;
            pin_a_o <= 1'b0;
            pin_a_oe_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_b_oe_o <= 1'b0;
            inv_pin_o <= 1'b0;
            inv_pin_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rdata_o <= 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    `RPT_ADDR_CTRL: rdata_o <= {7'h00, count_start_bit};
                    `RPT_ADDR_PIN: rdata_o <= pin_control_reg;
                    `RPT_ADDR_MODE: rdata_o <= timer_mode_reg;
                    `RPT_ADDR_ROUTE: rdata_o <= {6'h00, pin_route_reg};
                    `RPT_ADDR_PRE: rdata_o <= prescaler_value;
                    `RPT_ADDR_MAIN: rdata_o <= main_count_value;
                    default: rdata_o <= 8'h00;
                endcase
            end
            irq_o <= main_under;
            // Stopped drive hands the pin to the port latch bit
            pin_a_oe_o <= pin_route_reg == `RPT_ROUTE_A;
            pin_b_oe_o <= pin_route_reg == `RPT_ROUTE_B;
            pin_a_o <= pulse_output_stop ? pin_control_reg[`RPT_PIN_PORT1] : pulse_level;
            pin_b_o <= pulse_output_stop ? pin_control_reg[`RPT_PIN_PORT1] : pulse_level;
            inv_pin_oe_o <= 1'b1;
            inv_pin_o <= inverted_output_enable ? !pulse_level
                : pin_control_reg[`RPT_PIN_PORT2];
        end
    end

endmodule

// ===== tb/rpt_timer_checker.sv
`timescale 1ns/1ps
`include "rpt_defines.vh"
module rpt_timer_checker
#(
    parameter WIDTH = 8
)
(
    input wire mclk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire osc_clk_i,
    input wire sub_clk_i,
    input wire [7:0] rdata_o,
    input wire irq_o,
    input wire pin_a_o,
    input wire pin_a_oe_o,
    input wire pin_b_o,
    input wire pin_b_oe_o,
    input wire inv_pin_o,
    input wire inv_pin_oe_o
);
// ----
// Shadow of control bits
// ----
reg run, lvl, inv_en, ostop;
reg [1:0] route;
wire mode_wr = wr_i && addr_i == `RPT_ADDR_MODE;
wire rd_bad = rd_i && addr_i > `RPT_ADDR_MAIN;
always @(posedge mclk_i)
    if (reset_i)
        {run, lvl, inv_en, ostop, route} <= 6'h00;
    else if (wr_i && addr_i == `RPT_ADDR_CTRL)
        run <= wdata_i[0] && !wdata_i[2];
    else if (wr_i && addr_i == `RPT_ADDR_PIN)
        {inv_en, ostop, lvl} <= {wdata_i[3:2], wdata_i[0]};
    else if (wr_i && addr_i == `RPT_ADDR_ROUTE)
        route <= wdata_i[1:0];
default clocking cb @(posedge mclk_i);
endclocking
default disable iff (reset_i);
property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
property p_unmapped; $past(rd_bad) |-> rdata_o == 8'h00; endproperty
property p_inv_oe; !$past(reset_i) |-> inv_pin_oe_o; endproperty
property p_oe_excl; !(pin_a_oe_o && pin_b_oe_o); endproperty
property p_route_a; pin_a_oe_o |-> $past(route) == `RPT_ROUTE_A; endproperty
property p_route_b; pin_b_oe_o |-> $past(route) == `RPT_ROUTE_B; endproperty
property p_stop_irq; !run && !$past(run) && !$past(run, 2) |-> !irq_o; endproperty
property p_inv;
    inv_en && $past(inv_en, 2) && !ostop && !$past(ostop, 2) && pin_a_oe_o
        && $past(pin_a_oe_o) |-> inv_pin_o != pin_a_o;
endproperty
property p_mode_lvl;
    $past(mode_wr, 2) && !run && !ostop && pin_a_oe_o |-> pin_a_o == lvl;
endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
a_inv_oe: assert property (p_inv_oe) else $error("secondary pin undriven");
a_oe_excl: assert property (p_oe_excl) else $error("both routes driven");
a_route_a: assert property (p_route_a) else $error("route a wrong");
a_route_b: assert property (p_route_b) else $error("route b wrong");
a_stop_irq: assert property (p_stop_irq) else $error("irq while stopped");
a_inv: assert property (p_inv) else $error("secondary not inverted");
a_mode_lvl: assert property (p_mode_lvl) else $error("start level wrong");
c_irq: cover property (irq_o);
c_route_b: cover property (pin_b_oe_o);
c_inv: cover property (inv_en && pin_a_oe_o && inv_pin_o);
endmodule
bind rpt_timer rpt_timer_checker #(.WIDTH(WIDTH)) u_rpt_timer_checker (.mclk_i(mclk_i),
    .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .osc_clk_i(osc_clk_i), .sub_clk_i(sub_clk_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o),
    .pin_b_oe_o(pin_b_oe_o), .inv_pin_o(inv_pin_o), .inv_pin_oe_o(inv_pin_oe_o));

// ===== tb/rpt_pulse_sink.sv
`timescale 1ns/1ps
module rpt_pulse_sink
(
    input wire mclk_i,
    input wire pin_i,
    input wire irq_i,
    output reg [15:0] per_o = 16'h0000,
    output reg [15:0] edges_o = 16'h0000,
    output reg [15:0] irqs_o = 16'h0000
);
// Receiver only: it measures cycles between the last two level changes
// Case equality keeps the counts known while the pin is still unknown
reg last = 1'b0;
reg [15:0] gap = 16'h0000;
wire moved = pin_i !== last;
always @(posedge mclk_i)
begin
    last <= pin_i;
    gap <= moved ? 16'h0001 : gap + 16'h0001;
    per_o <= moved ? gap : per_o;
    edges_o <= edges_o + {15'h0000, moved};
    irqs_o <= irqs_o + {15'h0000, irq_i === 1'b1};
end
endmodule

// ===== tb/rpt_timer_tb_top.sv
`timescale 1ns/1ps
`include "rpt_defines.vh"
module rpt_timer_tb_top;
// Source order div1 div2 div8 osc sub32 sub; osc 12 and sub 10 cycles a period
localparam [17:0] SRCS = {3'h6, 3'h4, 3'h2, 3'h1, 3'h3, 3'h0};
localparam [59:0] MULT = {10'h00a, 10'h140, 10'h00c, 10'h008, 10'h002, 10'h001};
reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, osc = 1'b0, sub = 1'b0;
reg [3:0] addr = 4'h0;
reg [7:0] wdata = 8'h00, n, m;
reg [15:0] exp16, e0, q0;
reg [31:0] seed = 32'h0abd_ef64;
reg [7:0] expq [$];
wire [7:0] rdata;
wire [15:0] per, edges, irqs;
wire irq, pa, paoe, pb, pboe, inv, invoe;
integer fails = 0, comparisons = 0, cyc = 0, i;
always #5 clk = ~clk;
always #60 osc = ~osc;
always #50 sub = ~sub;
rpt_timer #(.WIDTH(8)) u_rpt_timer (.mclk_i(clk), .reset_i(rst), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .osc_clk_i(osc), .sub_clk_i(sub),
    .rdata_o(rdata), .irq_o(irq), .pin_a_o(pa), .pin_a_oe_o(paoe), .pin_b_o(pb),
    .pin_b_oe_o(pboe), .inv_pin_o(inv), .inv_pin_oe_o(invoe));
rpt_pulse_sink u_rpt_pulse_sink (.mclk_i(clk), .pin_i(pa), .irq_i(irq), .per_o(per),
    .edges_o(edges), .irqs_o(irqs));
function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task chk(input string what, input [15:0] exp, input [15:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask
task end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task bus_wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
endtask
task bus_rd(input [3:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
endtask
task settle;
    repeat (3) @(posedge clk);
    #1;
endtask
// Read data stand only in the cycle after the strobe
always @(posedge clk)
    rd_d <= rd;
always @(negedge clk)
    if (rd_d)
        chk("rdata", {8'h00, expq.pop_front()}, {8'h00, rdata});
always @(posedge clk)
begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
        fails = fails + 1;
        end_sim();
    end
end
initial
begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus_rd(`RPT_ADDR_PRE, `RPT_RST_CNT);
    bus_rd(`RPT_ADDR_MAIN, `RPT_RST_CNT);
    bus_wr(4'h9, 8'h5a);
    bus_rd(4'h9, 8'h00);
    $display("test reset done");
    bus_wr(`RPT_ADDR_ROUTE, {6'h00, `RPT_ROUTE_A});
    bus_wr(`RPT_ADDR_PIN, 8'h09);
    for (i = 0; i < 6; i = i + 1)
    begin
        seed = lfsr(seed);
        n = {6'h00, seed[1:0]};
        m = {6'h00, seed[3:2]};
        bus_wr(`RPT_ADDR_PRE, n);
        bus_wr(`RPT_ADDR_MAIN, m);
        bus_rd(`RPT_ADDR_PRE, n);
        bus_rd(`RPT_ADDR_MAIN, m);
        bus_wr(`RPT_ADDR_MODE, {1'b0, SRCS[3*i +: 3], 4'h0});
        settle();
        chk("level", 16'h0001, {15'h0000, pa});
        chk("inverted", 16'h0000, {15'h0000, inv});
        e0 = edges;
        q0 = irqs;
        bus_wr(`RPT_ADDR_CTRL, 8'h01);
        if (i == 4)
        begin
            bus_wr(`RPT_ADDR_MAIN, m);
            bus_rd(`RPT_ADDR_MAIN, m);
        end
        while (edges < e0 + 16'h0003)
            @(posedge clk);
        exp16 = MULT[10*i +: 10] * (n + 8'h01) * (m + 8'h01);
        chk("period", exp16, per);
        bus_wr(`RPT_ADDR_CTRL, i[0] ? 8'h05 : 8'h00);
        settle();
        chk("irqs", edges - e0, irqs - q0);
        e0 = edges;
        repeat (40) @(posedge clk);
        chk("hold", e0, edges);
        $display("test source %0d done", i);
    end
    bus_wr(`RPT_ADDR_ROUTE, {6'h00, `RPT_ROUTE_B});
    bus_wr(`RPT_ADDR_PIN, 8'h25);
    bus_wr(`RPT_ADDR_MODE, 8'h00);
    settle();
    chk("route b", 16'h0001, {15'h0000, pboe});
    chk("route a", 16'h0000, {15'h0000, paoe});
    chk("port", 16'h0000, {15'h0000, pb});
    chk("secondary port", 16'h0001, {15'h0000, inv});
    $display("test route done");
    end_sim();
end
endmodule
